// *** design/ubd_top.sv ***
/* Break detection on two serial receivers (plain and FIFO), break sending by pin override.
 Assumes 8N1 frames at the configured baud rate and an async rxd pin. */
// Overview of operation
// - Break gives all-zero frame: set framing error, parity error stays clear.
// - Plain unit halts reception fully after a break.
// - While halted: no shift into receive register, no transfer to data register.
// - Clearing transmitter enable resets transmitter at once; pin shows override level.
// - FIFO unit: break when framing error then space lasts over one frame.
// - On break FIFO unit stops pushing zero byte and stops shifting.
// - Break interrupt when receive or receive-error interrupt enable set.
// - FIFO unit resumes automatically when line returns to mark.
// - Live receive pin level readable via port input bit.
`timescale 1ns/10ps
`include "ubd_cfg.svh"
module ubd_top
	import ubd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic rxd_pin,
	output logic txd_pin,
	output logic rxd_port_level,
	input wire logic clear_error_flags,
	output logic framing_error_flag,
	output logic parity_error_flag,
	output logic overrun_error_flag,
	output logic [7:0] receive_data_reg,
	output logic receive_data_valid,
	input wire logic receive_data_read,
	input wire logic parity_enable,
	output logic [7:0] receive_fifo_data,
	output logic receive_fifo_valid,
	input wire logic receive_fifo_ready,
	output logic line_break_flag,
	input wire logic clear_break_flag,
	input wire logic receive_irq_enable,
	input wire logic receive_error_irq_enable,
	output logic line_break_irq,
	input wire logic transmitter_on,
	input wire logic txd_pin_override_enable,
	input wire logic txd_pin_override_level,
	input wire logic [7:0] transmit_data,
	input wire logic transmit_valid,
	output logic transmit_ready
);
	localparam int DIV = `UBD_TICK_DIV;
	localparam int FRAME_TICKS = `UBD_FRAME_BITS * `UBD_OVS;
	logic [2:0] sync_reg;
	logic rx_reg;
	logic [15:0] div_reg;
	logic tick;
	ubd_rx_state_t rx_state_reg;
	logic [3:0] ovs_reg;
	logic [2:0] bit_reg;
	logic [7:0] receive_shift_reg;
	logic [7:0] fifo_shift_reg;
	logic frame_done;
	logic stop_low;
	logic plain_halt_reg;
	logic fifo_hold_reg;
	logic [8:0] break_cnt_reg;
	logic push;
	ubd_tx_state_t tx_state_reg;
	logic [3:0] tovs_reg;
	logic [2:0] tbit_reg;
	logic [7:0] tx_shift_reg;
	logic tx_line_reg;
	// Third stage and second must agree before the level is taken
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sync_reg <= 3'h7;
			rx_reg <= 1'b1;
		end
		else
		begin
			sync_reg <= {sync_reg[1:0], rxd_pin};
			if (sync_reg[1] == sync_reg[2])
				rx_reg <= sync_reg[2];
		end
	end
	assign rxd_port_level = rx_reg;
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			div_reg <= '0;
		else if (div_reg == 16'(DIV - 1))
			div_reg <= '0;
		else
			div_reg <= div_reg + 16'h0001;
	end
	assign tick = (div_reg == 16'(DIV - 1));
	// Both units share one sampler; halts gate what each does with a frame
	assign frame_done = tick && rx_state_reg == UBD_STOP && ovs_reg == 4'hF;
	assign stop_low = !rx_reg;
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_state_reg <= UBD_IDLE;
			ovs_reg <= '0;
			bit_reg <= '0;
			receive_shift_reg <= '0;
			fifo_shift_reg <= '0;
		end
		else if (tick)
		begin
			ovs_reg <= ovs_reg + 4'h1;
			case (rx_state_reg)
				UBD_IDLE:
				begin
					ovs_reg <= '0;
					if (!rx_reg && !fifo_hold_reg && break_cnt_reg == 9'h000)
						rx_state_reg <= UBD_START;
				end
				UBD_START:
					if (ovs_reg == 4'h7)
					begin
						ovs_reg <= '0;
						rx_state_reg <= rx_reg ? UBD_IDLE : UBD_DATA;
						bit_reg <= '0;
					end
				UBD_DATA:
					if (ovs_reg == 4'hF)
					begin
						if (!plain_halt_reg)
							receive_shift_reg <= {rx_reg, receive_shift_reg[7:1]};
						fifo_shift_reg <= {rx_reg, fifo_shift_reg[7:1]};
						bit_reg <= bit_reg + 3'h1;
						if (bit_reg == 3'h7)
							rx_state_reg <= UBD_STOP;
					end
				UBD_STOP:
					if (ovs_reg == 4'hF)
						rx_state_reg <= UBD_IDLE;
				default:
					rx_state_reg <= UBD_IDLE;
			endcase
		end
	end
	// Plain unit: data register, error flags, halt after break
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			receive_data_reg <= '0;
			receive_data_valid <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag <= 1'b0;
			overrun_error_flag <= 1'b0;
			plain_halt_reg <= 1'b0;
		end
		else
		begin
			if (receive_data_read)
				receive_data_valid <= 1'b0;
			if (clear_error_flags)
			begin
				framing_error_flag <= 1'b0;
				parity_error_flag <= 1'b0;
				overrun_error_flag <= 1'b0;
				if (rx_reg)
					plain_halt_reg <= 1'b0;
			end
			// Set wins over a clear in the same cycle
			if (frame_done && !plain_halt_reg)
			begin
				if (parity_enable && (^receive_shift_reg[6:0]) != receive_shift_reg[7])
					parity_error_flag <= 1'b1;
				if (stop_low)
				begin
					framing_error_flag <= 1'b1;
					if (receive_shift_reg == 8'h00)
						plain_halt_reg <= 1'b1;
				end
				if (!(stop_low && receive_shift_reg == 8'h00))
				begin
					if (receive_data_valid && !receive_data_read)
						overrun_error_flag <= 1'b1;
					else
					begin
						receive_data_reg <= receive_shift_reg;
						receive_data_valid <= 1'b1;
					end
				end
			end
		end
	end
	// FIFO unit: break timer from framing error, automatic resume on mark
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			break_cnt_reg <= '0;
			fifo_hold_reg <= 1'b0;
			line_break_flag <= 1'b0;
		end
		else
		begin
			if (clear_break_flag)
				line_break_flag <= 1'b0;
			if (frame_done && stop_low)
				break_cnt_reg <= 9'h001;
			else if (break_cnt_reg != '0 && rx_reg)
				break_cnt_reg <= '0;
			else if (break_cnt_reg != '0 && tick && !fifo_hold_reg)
			begin
				break_cnt_reg <= break_cnt_reg + 9'h001;
				if (break_cnt_reg == 9'(FRAME_TICKS))
				begin
					fifo_hold_reg <= 1'b1;
					line_break_flag <= 1'b1;
				end
			end
			if (fifo_hold_reg && rx_reg)
				fifo_hold_reg <= 1'b0;
		end
	end
	assign line_break_irq = line_break_flag &&
		(receive_irq_enable || receive_error_irq_enable);
	// Any frame with framing error is dropped and never pushed, break or not
	assign push = frame_done && !fifo_hold_reg && !stop_low;
	ubd_fifo #(.WIDTH(`UBD_DATA_W), .DEPTH(`UBD_FIFO_DEPTH), .AW(`UBD_FIFO_AW)) u_fifo (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.in_data(fifo_shift_reg),
		.in_valid(push),
		.in_ready(),
		.out_data(receive_fifo_data),
		.out_valid(receive_fifo_valid),
		.out_ready(receive_fifo_ready),
		.level()
	);
	// Transmitter: clearing enable resets it mid-frame
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_state_reg <= UBD_T_IDLE;
			tovs_reg <= '0;
			tbit_reg <= '0;
			tx_shift_reg <= '0;
			tx_line_reg <= 1'b1;
		end
		else if (!transmitter_on)
		begin
			tx_state_reg <= UBD_T_IDLE;
			tovs_reg <= '0;
			tbit_reg <= '0;
			tx_line_reg <= 1'b1;
		end
		else
		begin
			case (tx_state_reg)
				UBD_T_IDLE:
					if (transmit_valid)
					begin
						tx_shift_reg <= transmit_data;
						tx_line_reg <= 1'b0;
						tovs_reg <= '0;
						tx_state_reg <= UBD_T_START;
					end
				UBD_T_START, UBD_T_DATA, UBD_T_STOP:
					if (tick)
					begin
						tovs_reg <= tovs_reg + 4'h1;
						if (tovs_reg == 4'hF)
						begin
							if (tx_state_reg == UBD_T_STOP)
								tx_state_reg <= UBD_T_IDLE;
							else if (tx_state_reg == UBD_T_START || tbit_reg != 3'h7)
							begin
								if (tx_state_reg == UBD_T_DATA)
									tbit_reg <= tbit_reg + 3'h1;
								tx_state_reg <= UBD_T_DATA;
								tx_line_reg <= tx_shift_reg[0];
								tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
							end
							else
							begin
								tbit_reg <= '0;
								tx_line_reg <= 1'b1;
								tx_state_reg <= UBD_T_STOP;
							end
						end
					end
				default:
					tx_state_reg <= UBD_T_IDLE;
			endcase
		end
	end
	assign transmit_ready = transmitter_on && tx_state_reg == UBD_T_IDLE;
	// Override takes the pin; break is sent by holding it low
	assign txd_pin = txd_pin_override_enable ? txd_pin_override_level : tx_line_reg;
endmodule

// *** design/ubd_cfg.svh ***
/*
 Timing counts and FIFO/data sizes for the break detect/send block.
 Assumes a 125 MHz system clock and 16x oversampling of the serial line.
*/
`ifndef UBD_CFG_SVH
`define UBD_CFG_SVH
`define UBD_CLK_HZ 125000000
`define UBD_BAUD 115200
`define UBD_OVS 16
`define UBD_TICK_DIV ((`UBD_CLK_HZ) / ((`UBD_BAUD) * (`UBD_OVS)))
`define UBD_FRAME_BITS 10
`define UBD_FIFO_DEPTH 16
`define UBD_FIFO_AW 4
`define UBD_DATA_W 8
`endif

// *** design/ubd_pkg.sv ***
/*
 Types for the break detect/send block.
 Assumes ubd_cfg.svh is compiled alongside.
*/
package ubd_pkg;
	typedef enum logic [1:0] {UBD_IDLE, UBD_START, UBD_DATA, UBD_STOP} ubd_rx_state_t;
	typedef enum logic [1:0] {UBD_T_IDLE, UBD_T_START, UBD_T_DATA, UBD_T_STOP} ubd_tx_state_t;
endpackage

// *** design/ubd_fifo.sv ***
/*
 Flip-flop FIFO with valid/ready on both sides.
 Assumes a single clock and asynchronous active-low reset.
*/
`timescale 1ns/10ps
module ubd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [AW:0] level
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;
	assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rd_reg];
	assign level = cnt_reg;
	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= wr_reg + AW'(1);
			if (pop)
				rd_reg <= rd_reg + AW'(1);
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// *** bench/ubd_chk_assertions.sv ***
/*
 Port checker for the break detect/send block.
 Assumes it is bound onto ubd_top; one clock domain.
*/
`timescale 1ns/10ps
module ubd_chk (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic rxd_pin,
	input wire logic txd_pin,
	input wire logic rxd_port_level,
	input wire logic framing_error_flag,
	input wire logic [7:0] receive_data_reg,
	input wire logic receive_data_valid,
	input wire logic receive_fifo_valid,
	input wire logic line_break_flag,
	input wire logic receive_irq_enable,
	input wire logic receive_error_irq_enable,
	input wire logic line_break_irq,
	input wire logic transmitter_on,
	input wire logic txd_pin_override_enable,
	input wire logic txd_pin_override_level
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_break_send;
		txd_pin_override_enable && !txd_pin_override_level && !transmitter_on;
	endsequence
	sequence s_halted;
		framing_error_flag && $past(framing_error_flag) && !rxd_port_level;
	endsequence
	chk_break_send_low: assert property (s_break_send [*2] |-> !txd_pin)
		else $error("txd not low in break send");
	chk_irq_gate: assert property (line_break_irq == (line_break_flag &&
		(receive_irq_enable || receive_error_irq_enable))) else $error("break irq wrong");
	chk_break_on_space: assert property ($rose(line_break_flag) |->
		!rxd_port_level && !$past(rxd_port_level)) else $error("break flag on mark");
	chk_break_no_push: assert property (line_break_flag && !rxd_port_level |->
		!$rose(receive_fifo_valid)) else $error("push during break");
	chk_fer_no_push: assert property ($rose(framing_error_flag) |->
		!$rose(receive_fifo_valid)) else $error("bad frame pushed");
	chk_fer_low_stop: assert property ($rose(framing_error_flag) |-> !rxd_port_level)
		else $error("framing error on high line");
	chk_halt_hold: assert property (s_halted |-> $stable(receive_data_reg) &&
		!$rose(receive_data_valid)) else $error("plain unit not halted");
	chk_port_level: assert property (!rxd_pin [*8] |-> !rxd_port_level)
		else $error("port level not following pin");
endmodule
bind ubd_top ubd_chk ubd_chk_i (.*);

// *** bench/ubd_remote.sv ***
/*
 Remote serial transmitter driving the receive line.
 Assumes 8N1, LSB first, line idles at mark.
*/
`timescale 1ns/10ps
`include "ubd_cfg.svh"
module ubd_remote (
	input wire logic clk_sys,
	output logic rxd_pin
);
	localparam int BIT_CYC = `UBD_TICK_DIV * `UBD_OVS;
	initial rxd_pin = 1'h1;
	// Caller enters just after a rising edge
	task automatic level(input logic v, input int n);
		rxd_pin <= v;
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic frame(input logic [7:0] d, input logic stop_bit);
		level(1'h0, BIT_CYC);
		for (int i = 0; i < 8; i++)
			level(d[i], BIT_CYC);
		level(stop_bit, BIT_CYC);
	endtask
endmodule

// *** bench/ubd_top_test.sv ***
/*
 Self-checking bench for break detect/send.
 Assumes ubd_remote on the receive line and a 125 MHz clock.
*/
`timescale 1ns/10ps
`include "ubd_cfg.svh"
module ubd_top_test;
	localparam int FRAME = `UBD_TICK_DIV * `UBD_OVS * `UBD_FRAME_BITS;
	logic clk_sys, reset_n, rxd_pin, txd_pin, rxd_port_level, clear_error_flags;
	logic framing_error_flag, parity_error_flag, overrun_error_flag, receive_data_valid;
	logic [7:0] receive_data_reg, receive_fifo_data, transmit_data;
	logic receive_data_read, parity_enable, receive_fifo_valid, receive_fifo_ready;
	logic line_break_flag, clear_break_flag, receive_irq_enable, receive_error_irq_enable;
	logic line_break_irq, transmitter_on, txd_pin_override_enable, txd_pin_override_level;
	logic transmit_valid, transmit_ready;
	int n_mismatch = 0;
	int num_checks = 0;
	ubd_top ubd_top_i (.*);
	ubd_remote ubd_remote_i (.clk_sys, .rxd_pin);
	initial
	begin
		clk_sys = 1'h0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic rd(input logic pv, input logic [7:0] pd, input logic fv, input logic [7:0] fd);
		chk("plain valid", receive_data_valid, pv);
		if (pv)
			chk("plain data", receive_data_reg, pd);
		chk("fifo valid", receive_fifo_valid, fv);
		if (fv)
			chk("fifo data", receive_fifo_data, fd);
		receive_data_read <= 1'h1;
		receive_fifo_ready <= 1'h1;
		@(posedge clk_sys);
		receive_data_read <= 1'h0;
		receive_fifo_ready <= 1'h0;
		@(posedge clk_sys);
	endtask
	// Watchdog well past the roughly 71k cycles of the sequence
	initial
	begin
		repeat (90000) @(posedge clk_sys);
		n_mismatch++;
		tally_and_finish();
	end
	initial
	begin
		{clear_error_flags, receive_data_read, parity_enable, receive_fifo_ready} = '0;
		{clear_break_flag, receive_irq_enable, receive_error_irq_enable} = '0;
		{txd_pin_override_enable, txd_pin_override_level, transmit_valid, reset_n} = '0;
		transmitter_on = 1'h1;
		transmit_data = 8'hC3;
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'h1;
		@(posedge clk_sys);
		chk("idle txd", txd_pin, 8'h01);
		transmit_valid <= 1'h1;
		@(posedge clk_sys);
		transmit_valid <= 1'h0;
		repeat (2000) @(posedge clk_sys);
		chk("tx busy", transmit_ready, 8'h00);
		txd_pin_override_enable <= 1'h1;
		@(posedge clk_sys);
		transmitter_on <= 1'h0;
		repeat (3) @(posedge clk_sys);
		chk("break txd", txd_pin, 8'h00);
		transmitter_on <= 1'h1;
		txd_pin_override_enable <= 1'h0;
		repeat (3) @(posedge clk_sys);
		chk("reinit txd", txd_pin, 8'h01);
		chk("tx ready", transmit_ready, 8'h01);
		ubd_remote_i.frame(8'hA5, 1'h1);
		ubd_remote_i.level(1'h1, 300);
		rd(1'h1, 8'hA5, 1'h1, 8'hA5);
		// Space held past one frame after the bad stop bit
		ubd_remote_i.frame(8'h00, 1'h0);
		ubd_remote_i.level(1'h0, FRAME + 2000);
		chk("framing", framing_error_flag, 8'h01);
		chk("break", line_break_flag, 8'h01);
		chk("port", rxd_port_level, 8'h00);
		chk("fifo", receive_fifo_valid, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			{receive_error_irq_enable, receive_irq_enable} <= i[1:0];
			repeat (2) @(posedge clk_sys);
			chk("irq", line_break_irq, {7'h00, |i[1:0]});
		end
		ubd_remote_i.level(1'h1, 2000);
		ubd_remote_i.frame(8'h3C, 1'h1);
		ubd_remote_i.level(1'h1, 300);
		rd(1'h0, 8'h00, 1'h1, 8'h3C);
		clear_error_flags <= 1'h1;
		clear_break_flag <= 1'h1;
		@(posedge clk_sys);
		clear_error_flags <= 1'h0;
		clear_break_flag <= 1'h0;
		repeat (2) @(posedge clk_sys);
		chk("flags", {framing_error_flag, parity_error_flag, overrun_error_flag}, 8'h00);
		chk("irq off", line_break_irq, 8'h00);
		// Odd parity frame, then a second frame left unread to overrun
		parity_enable <= 1'h1;
		ubd_remote_i.frame(8'h5B, 1'h1);
		ubd_remote_i.frame(8'h66, 1'h1);
		ubd_remote_i.level(1'h1, 300);
		chk("parity", parity_error_flag, 8'h01);
		chk("overrun", overrun_error_flag, 8'h01);
		rd(1'h1, 8'h5B, 1'h1, 8'h5B);
		rd(1'h0, 8'h00, 1'h1, 8'h66);
		tally_and_finish();
	end
endmodule
